// >>> dv/sysref_sync_regs_props.sv
// Purpose: port-level checks for the sysref sync and transmit gating register bank
// Assumes: single converter clock domain, bound to the top module
// Notes: gate and interrupt checks bound the cause of a change, not its full equation
`timescale 1ns/1ps
module sysref_sync_regs_props
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register port
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [sysref_sync_pkg::ADDR_W-1:0] cfg_addr,
    input wire logic [sysref_sync_pkg::DATA_W-1:0] cfg_rdata,
    input wire logic cfg_rvalid,
    // events and gating
    input wire logic sysref_edge,
    input wire logic lmfc_edge,
    input wire logic lmfc_realign,
    input wire logic jitter_irq,
    input wire logic txen,
    input wire logic output_gate_on
);
    import sysref_sync_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    chk_read_answer: assert property (cfg_rd |=> cfg_rvalid)
        else $error("read strobe got no answer");
    chk_answer_cause: assert property (cfg_rvalid |-> $past(cfg_rd))
        else $error("answer without read strobe");
    chk_unmapped_zero: assert property (cfg_rd && cfg_addr == 12'h100 |=> cfg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_delay_lsbs_zero: assert property
        (cfg_rd && cfg_addr == OFS_DELAY_LO |=> cfg_rdata[1:0] == 2'b00)
        else $error("delay low bits not zero");
    chk_delay_hi_res: assert property
        (cfg_rd && cfg_addr == OFS_DELAY_HI |=> cfg_rdata[7:4] == 4'h0)
        else $error("delay upper reserved bits set");
    chk_realign_cause: assert property (lmfc_realign |-> $past(sysref_edge))
        else $error("realign without sysref edge");
    chk_tally_write_clear: assert property
        ((cfg_wr && cfg_addr == OFS_TALLY && !sysref_edge) ##1 !sysref_edge ##1
        (cfg_rd && cfg_addr == OFS_TALLY && !sysref_edge) |=> cfg_rdata == 8'h00)
        else $error("tally not cleared by write");
    chk_gate_change_cause: assert property
        ($changed(output_gate_on) |-> $past(cfg_wr) ||
        $past(cfg_wr, 2) || $past(txen) != $past(txen, 2))
        else $error("output gate changed without cause");
    chk_irq_rise_cause: assert property
        ($rose(jitter_irq) |-> $past(lmfc_edge) || $past(lmfc_edge, 2) ||
        $past(lmfc_edge, 3) || $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("jitter interrupt rose without cause");

    cover property (lmfc_realign);
    cover property (jitter_irq);
    cover property (cfg_rvalid && cfg_rdata != 8'h00);
endmodule

bind sysref_sync_txen_ctrl_regs sysref_sync_regs_props props_u (.mclk(mclk), .rstn(rstn),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .sysref_edge(sysref_edge), .lmfc_edge(lmfc_edge),
    .lmfc_realign(lmfc_realign), .jitter_irq(jitter_irq), .txen(txen),
    .output_gate_on(output_gate_on));

// >>> dv/tb_sysref_sync_txen_ctrl_regs.sv
// Purpose: directed testbench for the sysref sync and transmit gating register bank
// Assumes: 40 MHz clock, stimulus launched by non-blocking assignment at the rising edge
// Notes: delays other than the mode-test 8 are chosen so that a one-cycle counting offset still clears to the same value
`timescale 1ns/1ps
module tb_sysref_sync_txen_ctrl_regs;
    import sysref_sync_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [ADDR_W-1:0] cfg_addr = '0;
    logic [DATA_W-1:0] cfg_wdata = '0;
    logic sysref_edge = 1'b0;
    logic lmfc_edge = 1'b0;
    logic [MEAS_W-1:0] sysref_edge_phase_in = '0;
    logic txen = 1'b0;
    logic hop_osc_reset = 1'b0;
    logic [DATA_W-1:0] cfg_rdata;
    logic cfg_rvalid, lmfc_realign, jitter_irq, input_gate_on, output_gate_on, osc_reset;
    logic fullscale_on, core_bias_off_a, core_bias_off_b;
    logic [FSC_W-1:0] fullscale_current_code;
    logic [TRIM_W-1:0] clock_trim;
    int fail_count = 0;
    int samples_checked = 0;

    sysref_sync_txen_ctrl_regs dut_u (.mclk, .rstn, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata,
        .cfg_rdata, .cfg_rvalid, .sysref_edge, .lmfc_edge, .sysref_edge_phase_in, .lmfc_realign,
        .jitter_irq, .txen, .hop_osc_reset, .input_gate_on, .output_gate_on, .osc_reset,
        .fullscale_on, .fullscale_current_code, .core_bias_off_a, .core_bias_off_b,
        .clock_trim);

    initial
    begin
        forever #12.5 mclk = ~mclk;
    end

    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge mclk);
        cfg_wr <= 1'b0;
    endtask

    // answer checked in the one cycle that the valid pulse stands
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge mclk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge mclk);
        cfg_rd <= 1'b0;
        @(negedge mclk);
        chk({3'h0, cfg_rvalid, cfg_rdata}, {4'h1, exp});
    endtask

    task automatic settle;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask

    // lmfc edge taken k cycles after the sysref edge; rl is the realign seen
    task automatic meas(input int k, input logic [11:0] ph, output logic rl);
        @(posedge mclk);
        sysref_edge <= 1'b1;
        sysref_edge_phase_in <= ph;
        @(posedge mclk);
        sysref_edge <= 1'b0;
        @(negedge mclk);
        rl = lmfc_realign;
        repeat (k - 1) @(posedge mclk);
        lmfc_edge <= 1'b1;
        @(posedge mclk);
        lmfc_edge <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    task automatic t_reset;
        rdchk(OFS_TX_GATING, 8'hc0);
        rdchk(OFS_BIAS_PD, 8'h03);
        rdchk(OFS_FSC_LO, 8'h03);
        rdchk(OFS_FSC_HI, 8'hff);
        rdchk(OFS_CLK_TRIM, 8'h00);
        rdchk(OFS_ALIGN_CTRL, 8'h00);
        rdchk(12'h100, 8'h00);
        chk({core_bias_off_a, core_bias_off_b, fullscale_current_code}, 12'hfff);
    endtask

    task automatic t_gating;
        wr(OFS_TX_GATING, 8'h00);
        settle;
        chk({8'h00, input_gate_on, output_gate_on, osc_reset, fullscale_on}, 12'h001);
        @(posedge mclk);
        hop_osc_reset <= 1'b1;
        settle;
        chk({8'h00, input_gate_on, output_gate_on, osc_reset, fullscale_on}, 12'h003);
        wr(OFS_TX_GATING, 8'hff);
        settle;
        chk({8'h00, input_gate_on, output_gate_on, osc_reset, fullscale_on}, 12'h002);
        rdchk(OFS_TX_GATING, 8'hcf);
        @(posedge mclk);
        txen <= 1'b1;
        settle;
        chk({8'h00, input_gate_on, output_gate_on, osc_reset, fullscale_on}, 12'h00d);
        wr(OFS_TX_GATING, 8'h42);
        settle;
        chk({8'h00, input_gate_on, output_gate_on, osc_reset, fullscale_on}, 12'h00b);
        @(posedge mclk);
        txen <= 1'b0;
        settle;
        chk({8'h00, input_gate_on, output_gate_on, osc_reset, fullscale_on}, 12'h003);
    endtask

    task automatic t_analog;
        wr(OFS_FSC_LO, 8'hfd);
        wr(OFS_FSC_HI, 8'h5a);
        wr(OFS_BIAS_PD, 8'hfe);
        wr(OFS_CLK_TRIM, 8'hff);
        rdchk(OFS_FSC_LO, 8'h01);
        rdchk(OFS_BIAS_PD, 8'h02);
        rdchk(OFS_CLK_TRIM, 8'h3f);
        chk({core_bias_off_a, core_bias_off_b, fullscale_current_code}, 12'h569);
        chk({6'h00, clock_trim}, 12'h03f);
    endtask

    task automatic t_measure;
        logic rl;
        wr(OFS_TALLY, 8'h00);
        meas(262, 12'hfff, rl);
        chk({11'h000, rl}, 12'h000);
        wr(OFS_DELAY_LO, 8'h00);
        rdchk(OFS_DELAY_LO, 8'h04);
        rdchk(OFS_DELAY_HI, 8'h01);
        rdchk(OFS_PHASE_LO, 8'hff);
        rdchk(OFS_PHASE_HI, 8'h0f);
        meas(14, 12'h007, rl);
        rdchk(OFS_DELAY_LO, 8'h04);
        rdchk(OFS_TALLY, 8'h02);
        wr(OFS_PHASE_HI, 8'h55);
        rdchk(OFS_DELAY_LO, 8'h0c);
        rdchk(OFS_PHASE_LO, 8'h07);
        wr(OFS_TALLY, 8'h5a);
        rdchk(OFS_TALLY, 8'h00);
    endtask

    // mode 0 runs last so that the jitter reference exists afterwards
    task automatic t_modes;
        logic r1;
        logic r2;
        for (int m = 3; m >= 0; m--)
        begin
            wr(OFS_ALIGN_CTRL, 8'hfc | 8'(m));
            meas(8, 12'h000, r1);
            meas(8, 12'h000, r2);
            chk({10'h000, r1, r2}, {10'h000, m == 1 || m == 2, m == 1});
            rdchk(OFS_ALIGN_CTRL, (m == 2) ? 8'h00 : 8'(m));
        end
    endtask

    task automatic t_jitter;
        logic rl;
        wr(OFS_JITTER_ALLOW, 8'hc7);
        rdchk(OFS_JITTER_ALLOW, 8'h07);
        wr(OFS_IRQ_STATUS, 8'h10);
        wr(OFS_IRQ_ENABLE, 8'h10);
        meas(9, 12'h000, rl);
        rdchk(OFS_IRQ_STATUS, 8'h00);
        meas(17, 12'h000, rl);
        rdchk(OFS_IRQ_STATUS, 8'h10);
        chk({11'h000, jitter_irq}, 12'h001);
        wr(OFS_IRQ_ENABLE, 8'h00);
        settle;
        chk({11'h000, jitter_irq}, 12'h000);
        wr(OFS_IRQ_STATUS, 8'h10);
        rdchk(OFS_IRQ_STATUS, 8'h00);
    endtask

    initial
    begin
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset;
        t_gating;
        t_analog;
        t_measure;
        t_modes;
        t_jitter;
        test_done;
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        $display("Error at %0t: run did not finish", $time);
        test_done;
    end
endmodule

// >>> inc/sysref_sync_pkg.sv
// Purpose: constants and types for the sysref sync and transmit gating register bank
// Assumes: 12-bit register addresses, 8-bit register data
// Notes: offsets are byte addresses on the serial configuration port
package sysref_sync_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int MEAS_W = 12;
    localparam int TALLY_W = 8;
    localparam int ALLOW_W = 6;
    localparam int FSC_W = 10;
    localparam int TRIM_W = 6;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h024;
    localparam logic [ADDR_W-1:0] OFS_DELAY_LO = 12'h034;
    localparam logic [ADDR_W-1:0] OFS_DELAY_HI = 12'h035;
    localparam logic [ADDR_W-1:0] OFS_TALLY = 12'h036;
    localparam logic [ADDR_W-1:0] OFS_PHASE_LO = 12'h037;
    localparam logic [ADDR_W-1:0] OFS_PHASE_HI = 12'h038;
    localparam logic [ADDR_W-1:0] OFS_JITTER_ALLOW = 12'h039;
    localparam logic [ADDR_W-1:0] OFS_ALIGN_CTRL = 12'h03a;
    localparam logic [ADDR_W-1:0] OFS_TX_GATING = 12'h03f;
    localparam logic [ADDR_W-1:0] OFS_BIAS_PD = 12'h040;
    localparam logic [ADDR_W-1:0] OFS_FSC_LO = 12'h041;
    localparam logic [ADDR_W-1:0] OFS_FSC_HI = 12'h042;
    localparam logic [ADDR_W-1:0] OFS_CLK_TRIM = 12'h07f;

    // field positions
    localparam int BIT_JITTER = 4;
    localparam int BIT_SW_OUTPUT_GATE = 7;
    localparam int BIT_SW_INPUT_GATE = 6;
    localparam int BIT_PIN_OSC_RESET = 3;
    localparam int BIT_PIN_OUTPUT_GATE = 2;
    localparam int BIT_PIN_INPUT_GATE = 1;
    localparam int BIT_PIN_FULLSCALE = 0;
    localparam int BIT_BIAS_B = 1;
    localparam int BIT_BIAS_A = 0;
    localparam int FSC_LO_W = 2;

    // reset values
    localparam logic [DATA_W-1:0] RST_TX_GATING = 8'hc0;
    localparam logic [1:0] RST_BIAS_PD = 2'h3;
    localparam logic [FSC_W-1:0] RST_FSC = 10'h3ff;
    localparam logic [TRIM_W-1:0] RST_CLK_TRIM = 6'h00;
    localparam logic [ALLOW_W-1:0] RST_JITTER_ALLOW = 6'h00;

    typedef enum logic [1:0] {
        SYNC_MONITOR = 2'b00,
        SYNC_CONTINUOUS = 2'b01,
        SYNC_ONESHOT = 2'b10,
        SYNC_SPARE = 2'b11
    } sync_mode_type;

endpackage

// >>> src/sysref_sync_txen_ctrl_regs.sv
// Purpose: sysref to frame clock monitor/alignment and transmit gating register bank
// Assumes: register port comes from the serial configuration engine, one access per strobe
// Notes: sysref and frame clock edge inputs are single-cycle pulses in the converter clock domain; the phase input is sampled on the sysref edge
`timescale 1ns/1ps

// Functional notes
// [RQ1] measured sysref-to-frame-clock delay, 12 bits in clocks, two lsbs read zero
// [RQ2] writing a delay or phase register snapshots the measurement, held for readback
// [RQ3] 8-bit count of sysref pulses; any write to it clears the count
// [RQ4] sysref_edge_phase captured as 12-bit thermometer code across two registers
// [RQ5] sysref variation beyond the allowance raises the jitter condition
// [RQ6] allowance in clocks; its lowest two bits are ignored in the compare
// [RQ7] mode 00 only monitors the delay, no realignment
// [RQ8] mode 10 realigns once on next sysref, then returns itself to monitor
// [RQ9] mode 01 realigns the frame clock on every sysref edge
// [RQ10] output gate bit 7, reset 1: zero data when clear, pass when set
// [RQ11] input gate bit 6, reset 1: zero lane data when clear, feed when set
// [RQ12] bit 3 picks oscillator reset source: hop bits or transmit-enable pin
// [RQ13] bit 2 picks output gate source: software bit or transmit-enable pin
// [RQ14] bit 1 picks input gate source: software bit or transmit-enable pin
// [RQ15] bit 0 picks full-scale current source: registers or transmit-enable pin
// [RQ16] pin-controlled functions: low pin means disabled, high means enabled
// [RQ17] two core bias power-down bits, reset 1, power down bias while set
// [RQ18] full-scale code 10 bits: low 2 bits reset 3, upper 8 reset ff
// [RQ19] 6-bit signed-magnitude clock input trim, reset zero
// [RQ20] jitter violation sets a sticky flag; writing one clears it
// [RQ21] jitter flag reaches the interrupt output only while enabled
module sysref_sync_txen_ctrl_regs
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register port
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [sysref_sync_pkg::ADDR_W-1:0] cfg_addr,
    input wire logic [sysref_sync_pkg::DATA_W-1:0] cfg_wdata,
    output logic [sysref_sync_pkg::DATA_W-1:0] cfg_rdata,
    output logic cfg_rvalid,
    // timing events
    input wire logic sysref_edge,
    input wire logic lmfc_edge,
    input wire logic [sysref_sync_pkg::MEAS_W-1:0] sysref_edge_phase_in,
    output logic lmfc_realign,
    output logic jitter_irq,
    // transmit enable and gating
    input wire logic txen,
    input wire logic hop_osc_reset,
    output logic input_gate_on,
    output logic output_gate_on,
    output logic osc_reset,
    output logic fullscale_on,
    // analog controls
    output logic [sysref_sync_pkg::FSC_W-1:0] fullscale_current_code,
    output logic core_bias_off_a,
    output logic core_bias_off_b,
    output logic [sysref_sync_pkg::TRIM_W-1:0] clock_trim
);
    import sysref_sync_pkg::*;

    typedef struct packed {
        logic running;
        logic [MEAS_W-1:0] dly_cnt;
        logic [MEAS_W-1:0] live_dly;
        logic [MEAS_W-1:0] prev_dly;
        logic have_prev;
        logic [MEAS_W-1:0] measured_frame_clock_delay;
        logic [MEAS_W-1:0] live_phase;
        logic [MEAS_W-1:0] sysref_edge_phase;
        logic [TALLY_W-1:0] sysref_pulse_tally;
        logic [ALLOW_W-1:0] sysref_jitter_allowance;
        sync_mode_type mode;
        logic sw_output_gate;
        logic sw_input_gate;
        logic pin_drives_osc_reset;
        logic pin_drives_output_gate;
        logic pin_drives_input_gate;
        logic pin_drives_fullscale;
        logic core_bias_off_a;
        logic core_bias_off_b;
        logic [FSC_W-1:0] fullscale_current_code;
        logic [TRIM_W-1:0] trim;
        logic jitter_violation_irq_on;
        logic jitter_violation_flag;
        logic realign;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic in_gate;
        logic out_gate;
        logic osc_rst;
        logic fs_on;
    } state_type;

    state_type state_q;
    state_type state_d;
    logic [1:0] rst_pipe_q;
    logic rst_n_sync;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // a gated function follows the pin or its other source (register bit, hop input or constant 1), never a mix of both
    function automatic logic source_pick(input logic by_pin, input logic pin_level,
        input logic reg_level);
        source_pick = by_pin ? pin_level : reg_level;
    endfunction

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rst_pipe_q <= 2'h0;
        else
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
    assign rst_n_sync = rst_pipe_q[1];

    logic [MEAS_W-1:0] new_dly;
    logic [MEAS_W-1:0] dly_diff;
    logic [MEAS_W-1:0] allow_ext;
    logic violation;
    logic wr_snap;

    always_comb
    begin
        state_d = state_q;
        state_d.realign = 1'b0;
        state_d.rvalid = 1'b0;
        new_dly = {state_q.dly_cnt[MEAS_W-1:2], 2'b00}; // [RQ1]
        // lowest two allowance bits dropped from the window [RQ6]
        allow_ext = {{(MEAS_W-ALLOW_W){1'b0}}, state_q.sysref_jitter_allowance[ALLOW_W-1:2],
            2'b00};
        dly_diff = (new_dly >= state_q.prev_dly) ? new_dly - state_q.prev_dly
            : state_q.prev_dly - new_dly;
        violation = 1'b0;
        wr_snap = cfg_wr && (hit(cfg_addr, OFS_DELAY_LO) || hit(cfg_addr, OFS_DELAY_HI)
            || hit(cfg_addr, OFS_PHASE_LO) || hit(cfg_addr, OFS_PHASE_HI));

        // delay counter runs from sysref edge to the next frame clock edge
        if (state_q.running && state_q.dly_cnt != {MEAS_W{1'b1}})
            state_d.dly_cnt = state_q.dly_cnt + 12'h001;
        if (state_q.running && lmfc_edge)
        begin
            state_d.running = 1'b0;
            state_d.live_dly = new_dly; // [RQ1]
            state_d.prev_dly = new_dly;
            state_d.have_prev = 1'b1;
            violation = state_q.have_prev && (dly_diff > allow_ext); // [RQ5] [RQ6]
        end
        if (sysref_edge)
        begin
            state_d.running = 1'b1;
            state_d.dly_cnt = 12'h000;
            state_d.live_phase = sysref_edge_phase_in; // [RQ4]
            state_d.sysref_pulse_tally = state_q.sysref_pulse_tally + 8'h01; // [RQ3]
            // a realign restarts the frame clock, so the old delay is no reference
            case (state_q.mode)
                SYNC_CONTINUOUS:
                begin
                    state_d.realign = 1'b1; // [RQ9]
                    state_d.have_prev = 1'b0;
                end
                SYNC_ONESHOT:
                begin
                    state_d.realign = 1'b1; // [RQ8]
                    state_d.have_prev = 1'b0;
                    state_d.mode = SYNC_MONITOR; // [RQ8]
                end
                default:
                begin
                    state_d.realign = 1'b0; // [RQ7]
                end
            endcase
        end

        // snapshot taken from the live value so readback cannot tear [RQ2]
        if (wr_snap)
        begin
            state_d.measured_frame_clock_delay = state_q.live_dly; // [RQ2]
            state_d.sysref_edge_phase = state_q.live_phase; // [RQ2]
        end

        if (cfg_wr)
        begin
            if (hit(cfg_addr, OFS_IRQ_ENABLE))
            begin
                state_d.jitter_violation_irq_on = cfg_wdata[BIT_JITTER]; // [RQ21]
            end
            else if (hit(cfg_addr, OFS_IRQ_STATUS) && cfg_wdata[BIT_JITTER])
            begin
                state_d.jitter_violation_flag = 1'b0; // [RQ20]
            end
            else if (hit(cfg_addr, OFS_TALLY))
            begin
                state_d.sysref_pulse_tally = {7'h00, sysref_edge}; // [RQ3]
            end
            else if (hit(cfg_addr, OFS_JITTER_ALLOW))
            begin
                state_d.sysref_jitter_allowance = cfg_wdata[ALLOW_W-1:0]; // [RQ6]
            end
            else if (hit(cfg_addr, OFS_ALIGN_CTRL))
            begin
                state_d.mode = sync_mode_type'(cfg_wdata[1:0]); // [RQ7]
            end
            else if (hit(cfg_addr, OFS_TX_GATING))
            begin
                state_d.sw_output_gate = cfg_wdata[BIT_SW_OUTPUT_GATE];
                state_d.sw_input_gate = cfg_wdata[BIT_SW_INPUT_GATE];
                state_d.pin_drives_osc_reset = cfg_wdata[BIT_PIN_OSC_RESET];
                state_d.pin_drives_output_gate = cfg_wdata[BIT_PIN_OUTPUT_GATE];
                state_d.pin_drives_input_gate = cfg_wdata[BIT_PIN_INPUT_GATE];
                state_d.pin_drives_fullscale = cfg_wdata[BIT_PIN_FULLSCALE];
            end
            else if (hit(cfg_addr, OFS_BIAS_PD))
            begin
                state_d.core_bias_off_a = cfg_wdata[BIT_BIAS_A]; // [RQ17]
                state_d.core_bias_off_b = cfg_wdata[BIT_BIAS_B]; // [RQ17]
            end
            else if (hit(cfg_addr, OFS_FSC_LO))
            begin
                state_d.fullscale_current_code[FSC_LO_W-1:0] = cfg_wdata[FSC_LO_W-1:0];
            end
            else if (hit(cfg_addr, OFS_FSC_HI))
            begin
                state_d.fullscale_current_code[FSC_W-1:FSC_LO_W] = cfg_wdata; // [RQ18]
            end
            else if (hit(cfg_addr, OFS_CLK_TRIM))
            begin
                state_d.trim = cfg_wdata[TRIM_W-1:0]; // [RQ19]
            end
        end
        // set beats a same-cycle clear
        if (violation)
            state_d.jitter_violation_flag = 1'b1; // [RQ20] [RQ5]

        // readback, reserved bits zero; snapshots reflect any write one cycle earlier
        if (cfg_rd)
        begin
            state_d.rvalid = 1'b1;
            if (hit(cfg_addr, OFS_IRQ_ENABLE))
            begin
                state_d.rdata = {3'h0, state_q.jitter_violation_irq_on, 4'h0};
            end
            else if (hit(cfg_addr, OFS_IRQ_STATUS))
            begin
                state_d.rdata = {3'h0, state_q.jitter_violation_flag, 4'h0};
            end
            else if (hit(cfg_addr, OFS_DELAY_LO))
            begin
                state_d.rdata = state_q.measured_frame_clock_delay[7:0]; // [RQ1]
            end
            else if (hit(cfg_addr, OFS_DELAY_HI))
            begin
                state_d.rdata = {4'h0, state_q.measured_frame_clock_delay[11:8]}; // [RQ1]
            end
            else if (hit(cfg_addr, OFS_TALLY))
            begin
                state_d.rdata = state_q.sysref_pulse_tally;
            end
            else if (hit(cfg_addr, OFS_PHASE_LO))
            begin
                state_d.rdata = state_q.sysref_edge_phase[7:0]; // [RQ4]
            end
            else if (hit(cfg_addr, OFS_PHASE_HI))
            begin
                state_d.rdata = {4'h0, state_q.sysref_edge_phase[11:8]}; // [RQ4]
            end
            else if (hit(cfg_addr, OFS_JITTER_ALLOW))
            begin
                state_d.rdata = {2'h0, state_q.sysref_jitter_allowance};
            end
            else if (hit(cfg_addr, OFS_ALIGN_CTRL))
            begin
                state_d.rdata = {6'h00, state_q.mode};
            end
            else if (hit(cfg_addr, OFS_TX_GATING))
            begin
                state_d.rdata = {state_q.sw_output_gate, state_q.sw_input_gate, 2'h0,
                    state_q.pin_drives_osc_reset, state_q.pin_drives_output_gate,
                    state_q.pin_drives_input_gate, state_q.pin_drives_fullscale};
            end
            else if (hit(cfg_addr, OFS_BIAS_PD))
            begin
                state_d.rdata = {6'h00, state_q.core_bias_off_b, state_q.core_bias_off_a};
            end
            else if (hit(cfg_addr, OFS_FSC_LO))
            begin
                state_d.rdata = {6'h00, state_q.fullscale_current_code[FSC_LO_W-1:0]};
            end
            else if (hit(cfg_addr, OFS_FSC_HI))
            begin
                state_d.rdata = state_q.fullscale_current_code[FSC_W-1:FSC_LO_W];
            end
            else if (hit(cfg_addr, OFS_CLK_TRIM))
            begin
                state_d.rdata = {2'h0, state_q.trim};
            end
            else
            begin
                state_d.rdata = 8'h00;
            end
        end

        // gating sources; a low pin means the disabled behaviour
        state_d.out_gate = source_pick(state_q.pin_drives_output_gate, txen,
            state_q.sw_output_gate); // [RQ13] [RQ10] [RQ16]
        state_d.in_gate = source_pick(state_q.pin_drives_input_gate, txen,
            state_q.sw_input_gate); // [RQ14] [RQ11] [RQ16]
        state_d.osc_rst = source_pick(state_q.pin_drives_osc_reset, ~txen,
            hop_osc_reset); // [RQ12] [RQ16]
        state_d.fs_on = source_pick(state_q.pin_drives_fullscale, txen, 1'b1); // [RQ15] [RQ16]
    end

    always_ff @(posedge mclk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            state_q <= '0;
            state_q.mode <= SYNC_MONITOR;
            state_q.sw_output_gate <= RST_TX_GATING[BIT_SW_OUTPUT_GATE]; // [RQ10]
            state_q.sw_input_gate <= RST_TX_GATING[BIT_SW_INPUT_GATE]; // [RQ11]
            state_q.core_bias_off_a <= RST_BIAS_PD[BIT_BIAS_A]; // [RQ17]
            state_q.core_bias_off_b <= RST_BIAS_PD[BIT_BIAS_B]; // [RQ17]
            state_q.fullscale_current_code <= RST_FSC; // [RQ18]
            state_q.trim <= RST_CLK_TRIM; // [RQ19]
            state_q.sysref_jitter_allowance <= RST_JITTER_ALLOW;
            state_q.out_gate <= 1'b1;
            state_q.in_gate <= 1'b1;
            state_q.fs_on <= 1'b1;
        end
        else
            state_q <= state_d;
    end

    assign cfg_rdata = state_q.rdata;
    assign cfg_rvalid = state_q.rvalid;
    assign lmfc_realign = state_q.realign;
    assign jitter_irq = state_q.jitter_violation_flag
        & state_q.jitter_violation_irq_on; // [RQ21]
    assign input_gate_on = state_q.in_gate;
    assign output_gate_on = state_q.out_gate;
    assign osc_reset = state_q.osc_rst;
    assign fullscale_on = state_q.fs_on;
    assign fullscale_current_code = state_q.fullscale_current_code;
    assign core_bias_off_a = state_q.core_bias_off_a;
    assign core_bias_off_b = state_q.core_bias_off_b;
    assign clock_trim = state_q.trim;

endmodule
